/* src/afd_defs.svh */
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: 15-bit serial port addresses, byte-wide registers
// Notes:   included by bare name
`ifndef AFD_DEFS_SVH
`define AFD_DEFS_SVH
`define AFD_A_UTH0   15'h247
`define AFD_A_UTH1   15'h248
`define AFD_A_LTH0   15'h249
`define AFD_A_LTH1   15'h24a
`define AFD_A_DWL0   15'h24b
`define AFD_A_DWL1   15'h24c
`define AFD_A_SMC    15'h270
`define AFD_A_PER0   15'h271
`define AFD_A_PER1   15'h272
`define AFD_A_PER2   15'h273
`define AFD_A_PKA0   15'h274
`define AFD_A_PKA1   15'h275
`define AFD_A_PKB0   15'h276
`define AFD_A_PKB1   15'h277
`define AFD_A_FDC    15'h559
`define AFD_A_ORC    15'h562
`define AFD_A_ORS    15'h563
`define AFD_SMC_PEAK_BIT 1
`define AFD_FDC_EN_BIT   0
`define AFD_REG_RST  8'h00
`define AFD_MAG_SAT  13'h1fff
`define AFD_FD_LAT_MAX 28
`endif

/* src/afd_fast_detect.sv */
// Purpose: per-channel threshold flag with hysteresis and dwell
// Assumes: one magnitude per clock
// Notes:   flag appears two clocks after the sample
`timescale 1ns/1ps
`default_nettype none
module afd_fast_detect #(
  parameter int MAG_W = 13,
  parameter int DW_W  = 16
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic             i_en,
  input  wire logic [MAG_W-1:0] i_mag,
  input  wire logic [MAG_W-1:0] i_uth,
  input  wire logic [MAG_W-1:0] i_lth,
  input  wire logic [DW_W-1:0]  i_dwell,
  output logic                  o_flag
);
  logic            flag_ff;
  logic [DW_W-1:0] cnt_ff;
  wire above = i_mag > i_uth;
  wire below = i_mag < i_lth;
  wire dwell_done = cnt_ff >= i_dwell;

  // set at once, clear after dwell below lower threshold
  always_ff @(posedge i_mclk) begin
    if (i_rst || !i_en) begin
      flag_ff <= 1'b0;
      cnt_ff  <= '0;
    end else if (above) begin
      flag_ff <= 1'b1;
      cnt_ff  <= '0;
    end else if (flag_ff && below) begin
      if (dwell_done) begin
        flag_ff <= 1'b0;
        cnt_ff  <= '0;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end else begin
      cnt_ff <= '0;
    end
  end
  assign o_flag = flag_ff;

  a_fd_set: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_en && above |=> flag_ff) else $error("flag not set above upper");
  a_fd_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    $fell(flag_ff) && $past(i_en) |-> $past(below) && $past(cnt_ff) >= $past(i_dwell))
    else $error("flag cleared before dwell elapsed");
  a_dwell_restart: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_en && flag_ff && !below |=> cnt_ff == '0) else $error("dwell count kept");
  c_fd_clear: cover property (@(posedge i_mclk) $fell(flag_ff) && $past(i_en));
endmodule : afd_fast_detect
`default_nettype wire

/* src/afd_peak_monitor.sv */
// Purpose: peak magnitude over a programmed number of decimated samples
// Assumes: i_dec_en is a one-clock pulse per decimated sample
// Notes:   holding register keeps last result while disabled
`timescale 1ns/1ps
`default_nettype none
module afd_peak_monitor #(
  parameter int MAG_W = 13,
  parameter int PER_W = 24
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic             i_en,
  input  wire logic             i_dec_en,
  input  wire logic [MAG_W-1:0] i_mag,
  input  wire logic [PER_W-1:0] i_period,
  output logic      [MAG_W-1:0] o_peak
);
  logic [PER_W-1:0] tmr_ff;
  logic [MAG_W-1:0] store_ff;
  logic [MAG_W-1:0] hold_ff;
  logic             en_d_ff;
  logic             seed_ff;
  wire start = i_en && !en_d_ff;
  wire last  = tmr_ff == PER_W'(1);
  wire [MAG_W-1:0] best = (seed_ff || i_mag > store_ff) ? i_mag : store_ff;

  // timer, magnitude store and holding register
  always_ff @(posedge i_mclk) begin
    en_d_ff <= i_rst ? 1'b0 : i_en;
    if (i_rst) begin
      tmr_ff <= '0;
      store_ff <= '0;
      hold_ff <= '0;
      seed_ff <= 1'b0;
    end else if (start) begin
      tmr_ff <= i_period;
      store_ff <= i_mag;
      seed_ff <= 1'b0;
    end else if (i_en && i_dec_en) begin
      store_ff <= best;
      seed_ff <= last;
      if (last) begin
        hold_ff <= best;
        tmr_ff <= i_period;
      end else begin
        tmr_ff <= tmr_ff - 1'b1;
      end
    end
  end
  assign o_peak = hold_ff;

  a_pm_load: assert property (@(posedge i_mclk) disable iff (i_rst)
    start |=> tmr_ff == $past(i_period)) else $error("period not loaded");
  a_pm_reload: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_en && en_d_ff && i_dec_en && last |=> hold_ff == $past(best)
      && tmr_ff == $past(i_period) && seed_ff) else $error("period end wrong");
  a_pm_peak: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_en && en_d_ff && i_dec_en && !seed_ff |=> store_ff >= $past(i_mag))
    else $error("store below sample");
  c_pm_end: cover property (@(posedge i_mclk) i_en && i_dec_en && last);
endmodule : afd_peak_monitor
`default_nettype wire

/* src/afd_pkg.sv */
// Purpose: shared types of the amplitude supervision block
// Assumes: nothing
// Notes:   constants live in afd_defs.svh
package afd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_WDATA, ST_RDATA, ST_WAIT
  } afd_spi_type;
endpackage : afd_pkg

/* src/afd_top.sv */
// Purpose: overrange, fast detect and signal monitor for two channels
// Assumes: one sample per i_mclk, serial port slower than i_mclk/8
// Notes:   serial frame is 16 instruction bits then 8 data bits
`timescale 1ns/1ps
`default_nettype none
`include "afd_defs.svh"

// Notes on behaviour
// - overrange flag delayed to match sample latency
// - status pins carry overrange only with chip-select high
// - four sticky overrange bits, one per virtual converter
// - clear-register bit set clears matching sticky bit
// - flag set immediately above upper threshold when enabled
// - flag clears after dwell time below lower threshold
// - upper threshold two bytes, flag within 28 clocks
// - lower threshold 13 bits over two registers
// - thresholds on magnitude scale, full scale two^13
// - dwell time 1 to 65535 clocks, two registers
// - each channel own detector and own pin
// - peak is 13-bit magnitude over 24-bit period
// - period programmed first, control bit 1 enables
// - enable loads period into decimated down-counter
// - store seeded with magnitude, then keeps maximum
// - at count one copy peak, reload, reseed
// - peak holding register readable over serial port
module afd_top
  import afd_pkg::*;
#(
  parameter int SMP_W   = 14,
  parameter int MAG_W   = 13,
  parameter int PER_W   = 24,
  parameter int SMP_LAT = 1
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic             i_spi_csb,
  input  wire logic             i_spi_sclk,
  input  wire logic             i_spi_sdi,
  output logic                  o_spi_sdo,
  output logic                  o_spi_sdo_oe,
  input  wire logic [SMP_W-1:0] i_smp_a,
  input  wire logic [SMP_W-1:0] i_smp_b,
  input  wire logic [1:0]       i_core_ovr,
  input  wire logic [3:0]       i_vc_ovr,
  input  wire logic             i_dec_en,
  output logic                  o_status_p,
  output logic                  o_status_n,
  output logic                  o_threshold_flag_pin_first,
  output logic                  o_threshold_flag_pin_second
);
  // pin synchronisers, three stages each
  logic [2:0] csb_s_ff;
  logic [2:0] sclk_s_ff;
  logic [2:0] sdi_s_ff;
  logic       csb_ff;
  logic       sclk_ff;
  logic       sclk_d_ff;
  logic       sdi_ff;

  // serial port state
  afd_spi_type st_ff;
  logic [15:0] ish_ff;
  logic [7:0]  wsh_ff;
  logic [7:0]  rsh_ff;
  logic [3:0]  cnt_ff;
  logic        sdo_ff;
  logic        wr_en_ff;
  logic [14:0] wr_addr_ff;
  logic [7:0]  wr_data_ff;

  // registers
  logic [7:0]  uth0_ff;
  logic [7:0]  uth1_ff;
  logic [7:0]  lth0_ff;
  logic [7:0]  lth1_ff;
  logic [7:0]  dwl0_ff;
  logic [7:0]  dwl1_ff;
  logic [7:0]  smc_ff;
  logic [7:0]  per0_ff;
  logic [7:0]  per1_ff;
  logic [7:0]  per2_ff;
  logic [7:0]  fdc_ff;
  logic [7:0]  orc_ff;
  logic [3:0]  sticky_ff;
  logic [SMP_LAT-1:0] ovr_dly_ff;
  logic        status_ff;

  // per-channel datapath
  logic [SMP_W-1:0] smp [2];
  logic [MAG_W-1:0] mag_ff [2];
  logic [MAG_W-1:0] peak [2];
  logic [1:0]       flag;

  // synchroniser: clean level moves once stages two and three agree
  always_ff @(posedge i_mclk) begin
    csb_s_ff  <= {csb_s_ff[1:0], i_spi_csb};
    sclk_s_ff <= {sclk_s_ff[1:0], i_spi_sclk};
    sdi_s_ff  <= {sdi_s_ff[1:0], i_spi_sdi};
  end

  // filtered pin levels
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      csb_ff    <= 1'b1;
      sclk_ff   <= 1'b0;
      sclk_d_ff <= 1'b0;
      sdi_ff    <= 1'b0;
    end else begin
      if (csb_s_ff[1] == csb_s_ff[2]) csb_ff <= csb_s_ff[2];
      if (sclk_s_ff[1] == sclk_s_ff[2]) sclk_ff <= sclk_s_ff[2];
      if (sdi_s_ff[1] == sdi_s_ff[2]) sdi_ff <= sdi_s_ff[2];
      sclk_d_ff <= sclk_ff;
    end
  end

  // serial clock edges and instruction fields
  wire        sclk_rise = sclk_ff && !sclk_d_ff;
  wire        sclk_fall = !sclk_ff && sclk_d_ff;
  wire        ins_rd    = ish_ff[14];
  wire [14:0] ins_addr  = {ish_ff[13:0], sdi_ff};
  wire        ins_last  = (st_ff == ST_ADDR) && sclk_rise && cnt_ff == 4'hf;
  wire        dat_last  = sclk_rise && cnt_ff == 4'h7;
  wire [7:0]  rdata;

  // serial port frame sequencer
  always_ff @(posedge i_mclk) begin
    if (i_rst || csb_ff) begin
      st_ff  <= ST_IDLE;
      cnt_ff <= 4'h0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          st_ff  <= ST_ADDR;
          cnt_ff <= 4'h0;
        end
        ST_ADDR: begin
          if (sclk_rise) cnt_ff <= cnt_ff + 4'h1;
          if (ins_last) st_ff <= ins_rd ? ST_RDATA : ST_WDATA;
        end
        ST_WDATA: begin
          if (sclk_rise) cnt_ff <= cnt_ff + 4'h1;
          if (sclk_rise && cnt_ff == 4'h7) st_ff <= ST_WAIT;
        end
        ST_RDATA: begin
          if (sclk_fall) cnt_ff <= cnt_ff + 4'h1;
          if (sclk_fall && cnt_ff == 4'h7) st_ff <= ST_WAIT;
        end
        ST_WAIT: st_ff <= ST_WAIT;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // shift registers: instruction in, write data in, read data out
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ish_ff <= 16'h0000;
      wsh_ff <= 8'h00;
      rsh_ff <= 8'h00;
      sdo_ff <= 1'b0;
    end else begin
      if (st_ff == ST_ADDR && sclk_rise) ish_ff <= {ish_ff[14:0], sdi_ff};
      if (st_ff == ST_WDATA && sclk_rise) wsh_ff <= {wsh_ff[6:0], sdi_ff};
      if (ins_last) rsh_ff <= rdata;
      if (st_ff == ST_RDATA && sclk_fall) begin
        sdo_ff <= rsh_ff[7];
        rsh_ff <= {rsh_ff[6:0], 1'b0};
      end
    end
  end

  // write strobe after the eighth data bit
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wr_en_ff   <= 1'b0;
      wr_addr_ff <= 15'h0000;
      wr_data_ff <= 8'h00;
    end else begin
      wr_en_ff <= !csb_ff && st_ff == ST_WDATA && dat_last;
      if (ins_last) wr_addr_ff <= ins_addr;
      if (st_ff == ST_WDATA && dat_last) wr_data_ff <= {wsh_ff[6:0], sdi_ff};
    end
  end
  assign o_spi_sdo    = sdo_ff;
  assign o_spi_sdo_oe = (st_ff == ST_RDATA) || (st_ff == ST_WAIT && ish_ff[15]);

  // register write decode
  wire we_uth0 = wr_en_ff && wr_addr_ff == `AFD_A_UTH0;
  wire we_uth1 = wr_en_ff && wr_addr_ff == `AFD_A_UTH1;
  wire we_lth0 = wr_en_ff && wr_addr_ff == `AFD_A_LTH0;
  wire we_lth1 = wr_en_ff && wr_addr_ff == `AFD_A_LTH1;
  wire we_dwl0 = wr_en_ff && wr_addr_ff == `AFD_A_DWL0;
  wire we_dwl1 = wr_en_ff && wr_addr_ff == `AFD_A_DWL1;
  wire we_smc  = wr_en_ff && wr_addr_ff == `AFD_A_SMC;
  wire we_per0 = wr_en_ff && wr_addr_ff == `AFD_A_PER0;
  wire we_per1 = wr_en_ff && wr_addr_ff == `AFD_A_PER1;
  wire we_per2 = wr_en_ff && wr_addr_ff == `AFD_A_PER2;
  wire we_fdc  = wr_en_ff && wr_addr_ff == `AFD_A_FDC;
  wire we_orc  = wr_en_ff && wr_addr_ff == `AFD_A_ORC;

  // writable registers
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      {uth0_ff, uth1_ff, lth0_ff, lth1_ff} <= {4{`AFD_REG_RST}};
      {dwl0_ff, dwl1_ff, smc_ff, fdc_ff}   <= {4{`AFD_REG_RST}};
      {per0_ff, per1_ff, per2_ff, orc_ff}  <= {4{`AFD_REG_RST}};
    end else begin
      if (we_uth0) uth0_ff <= wr_data_ff;
      if (we_uth1) uth1_ff <= wr_data_ff;
      if (we_lth0) lth0_ff <= wr_data_ff;
      if (we_lth1) lth1_ff <= wr_data_ff;
      if (we_dwl0) dwl0_ff <= wr_data_ff;
      if (we_dwl1) dwl1_ff <= wr_data_ff;
      if (we_smc)  smc_ff  <= wr_data_ff;
      if (we_per0) per0_ff <= wr_data_ff;
      if (we_per1) per1_ff <= wr_data_ff;
      if (we_per2) per2_ff <= wr_data_ff;
      if (we_fdc)  fdc_ff  <= wr_data_ff;
      if (we_orc)  orc_ff  <= wr_data_ff;
    end
  end

  // register fields
  wire [MAG_W-1:0] uth    = {uth1_ff[4:0], uth0_ff};
  wire [MAG_W-1:0] lth    = {lth1_ff[4:0], lth0_ff};
  wire [15:0]      dwell  = {dwl1_ff, dwl0_ff};
  wire [PER_W-1:0] period = {per2_ff, per1_ff, per0_ff};
  wire             fd_en  = fdc_ff[`AFD_FDC_EN_BIT];
  wire             pk_en  = smc_ff[`AFD_SMC_PEAK_BIT];

  // read mux on the address just shifted in
  assign rdata =
    ins_addr == `AFD_A_UTH0 ? uth0_ff :
    ins_addr == `AFD_A_UTH1 ? uth1_ff :
    ins_addr == `AFD_A_LTH0 ? lth0_ff :
    ins_addr == `AFD_A_LTH1 ? lth1_ff :
    ins_addr == `AFD_A_DWL0 ? dwl0_ff :
    ins_addr == `AFD_A_DWL1 ? dwl1_ff :
    ins_addr == `AFD_A_SMC  ? smc_ff  :
    ins_addr == `AFD_A_PER0 ? per0_ff :
    ins_addr == `AFD_A_PER1 ? per1_ff :
    ins_addr == `AFD_A_PER2 ? per2_ff :
    ins_addr == `AFD_A_PKA0 ? peak[0][7:0] :
    ins_addr == `AFD_A_PKA1 ? {3'h0, peak[0][12:8]} :
    ins_addr == `AFD_A_PKB0 ? peak[1][7:0] :
    ins_addr == `AFD_A_PKB1 ? {3'h0, peak[1][12:8]} :
    ins_addr == `AFD_A_FDC  ? fdc_ff :
    ins_addr == `AFD_A_ORC  ? orc_ff :
    ins_addr == `AFD_A_ORS  ? {4'h0, sticky_ff} : 8'h00;

  // sticky overrange per virtual converter, set wins over clear
  always_ff @(posedge i_mclk) begin
    if (i_rst) sticky_ff <= 4'h0;
    else sticky_ff <= (sticky_ff & ~orc_ff[3:0]) | i_vc_ovr;
  end

  // overrange delayed by the sample latency, gated by chip-select
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ovr_dly_ff <= '0;
      status_ff  <= 1'b0;
    end else begin
      ovr_dly_ff <= SMP_LAT'({ovr_dly_ff, |i_core_ovr});
      status_ff  <= ovr_dly_ff[SMP_LAT-1] && csb_ff;
    end
  end
  assign o_status_p = status_ff;
  assign o_status_n = !status_ff;

  // per-channel magnitude, fast detect and peak monitor
  assign smp[0] = i_smp_a;
  assign smp[1] = i_smp_b;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      wire [SMP_W-1:0] absv = smp[ch][SMP_W-1] ? SMP_W'(-smp[ch]) : smp[ch];
      wire [MAG_W-1:0] mag  = absv[SMP_W-1] ? `AFD_MAG_SAT : absv[MAG_W-1:0];
      always_ff @(posedge i_mclk) begin
        if (i_rst) mag_ff[ch] <= '0;
        else mag_ff[ch] <= mag;
      end
      afd_fast_detect #(.MAG_W(MAG_W), .DW_W(16)) u_fd (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_en    (fd_en),
        .i_mag   (mag_ff[ch]),
        .i_uth   (uth),
        .i_lth   (lth),
        .i_dwell (dwell),
        .o_flag  (flag[ch])
      );
      afd_peak_monitor #(.MAG_W(MAG_W), .PER_W(PER_W)) u_pm (
        .i_mclk   (i_mclk),
        .i_rst    (i_rst),
        .i_en     (pk_en),
        .i_dec_en (i_dec_en),
        .i_mag    (mag_ff[ch]),
        .i_period (period),
        .o_peak   (peak[ch])
      );
    end
  endgenerate
  assign o_threshold_flag_pin_first  = flag[0];
  assign o_threshold_flag_pin_second = flag[1];

  a_sticky_set: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_vc_ovr[0] |=> sticky_ff[0]) else $error("sticky bit not set");
  a_sticky_keep: assert property (@(posedge i_mclk) disable iff (i_rst)
    sticky_ff[1] && !orc_ff[1] |=> sticky_ff[1]) else $error("sticky bit lost");
  a_sticky_clr: assert property (@(posedge i_mclk) disable iff (i_rst)
    orc_ff[2] && !i_vc_ovr[2] |=> !sticky_ff[2]) else $error("clear ignored");
  a_status_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
    !$past(csb_ff) |-> !status_ff) else $error("status with csb low");
  a_fd_latency: assert property (@(posedge i_mclk) disable iff (i_rst)
    fd_en && g_ch[0].mag > uth ##1 fd_en && mag_ff[0] > uth |-> ##[1:26] flag[0])
    else $error("flag later than 28 clocks");
  c_spi_write: cover property (@(posedge i_mclk) wr_en_ff && we_smc);
  c_spi_read: cover property (@(posedge i_mclk) ins_last && ins_rd);
endmodule : afd_top
`default_nettype wire

/* verif/afd_spi_host.sv */
// Purpose: serial host model standing in for the control processor
// Assumes: each sclk level lasts 8 mclk, csb high at least 7 mclk
// Notes:   sdi is inverted after the last clock, 4 mclk before deselection
`timescale 1ns/1ps
`default_nettype none
module afd_spi_host (
  input  wire logic       i_mclk,
  input  wire logic       i_sdo,
  output logic            o_csb,
  output logic            o_sclk,
  output logic            o_sdi,
  output logic [7:0]      o_rdata,
  output logic            o_rvalid
);
  // idle: deselected, clock parked low
  initial begin
    o_csb    = 1'b1;
    o_sclk   = 1'b0;
    o_sdi    = 1'b0;
    o_rdata  = 8'h00;
    o_rvalid = 1'b0;
  end

  // one frame: read flag, address, one data byte, msb first
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d);
    logic [23:0] fr;
    fr = {rd, a, d};
    @(posedge i_mclk);
    o_csb <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (8) @(posedge i_mclk);
      o_sclk <= 1'b0;
      o_sdi  <= fr[i];
      repeat (8) @(posedge i_mclk);
      o_sclk <= 1'b1;
      if (i < 8) begin
        o_rdata[i] <= i_sdo;  // taken at the rising edge
      end
    end
    repeat (8) @(posedge i_mclk);
    o_sclk <= 1'b0;
    o_sdi  <= ~fr[0];
    repeat (4) @(posedge i_mclk);
    o_csb    <= 1'b1;
    o_rvalid <= rd;
    @(posedge i_mclk);
    o_rvalid <= 1'b0;
    repeat (6) @(posedge i_mclk);
  endtask : xfer
endmodule : afd_spi_host
`default_nettype wire

/* verif/afd_top_tb.sv */
// Purpose: self-checking bench for the amplitude supervision block
// Assumes: afd_spi_host plays the serial host
// Notes:   read bytes are scored against a queue of expected values
`timescale 1ns/1ps
`default_nettype none
`include "afd_defs.svh"
module afd_top_tb;
  localparam int LAT = 1;
  localparam int DWL = 4;
  localparam logic [14:0] RA [9] = '{`AFD_A_UTH0, `AFD_A_UTH1, `AFD_A_LTH0,
    `AFD_A_LTH1, `AFD_A_DWL0, `AFD_A_DWL1, `AFD_A_PER0, `AFD_A_PER1, `AFD_A_PER2};
  logic        i_mclk, i_rst, dec_en, sdo_fill, hit;
  logic [13:0] smp_a, smp_b;
  logic [1:0]  core_ovr;
  logic [3:0]  vc_ovr;
  logic [7:0]  exp_q [$];
  logic [7:0]  e;
  logic [7:0]  v8 [9];
  wire         csb, sclk, sdi, sdo, sdo_oe, st_p, st_n, fl_a, fl_b, rvalid;
  wire  [7:0]  rdata;
  wire  [1:0]  fl = {fl_b, fl_a};
  wire         sdo_line = sdo_oe ? sdo : sdo_fill;
  int          fails, compares, cyc, n, pa, pb, pa2;

  // clock
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  afd_top #(.SMP_LAT(LAT)) u_afd_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_spi_csb(csb),
    .i_spi_sclk(sclk), .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe),
    .i_smp_a(smp_a), .i_smp_b(smp_b), .i_core_ovr(core_ovr), .i_vc_ovr(vc_ovr),
    .i_dec_en(dec_en), .o_status_p(st_p), .o_status_n(st_n),
    .o_threshold_flag_pin_first(fl_a), .o_threshold_flag_pin_second(fl_b));

  afd_spi_host u_afd_spi_host (.i_mclk(i_mclk), .i_sdo(sdo_line), .o_csb(csb),
    .o_sclk(sclk), .o_sdi(sdi), .o_rdata(rdata), .o_rvalid(rvalid));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    u_afd_spi_host.xfer(1'b0, a, d);
  endtask : wr

  task automatic wr16(input logic [14:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 15'h1, v[15:8]);
  endtask : wr16

  // note the expected byte, then run the read frame
  task automatic rd(input logic [14:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    u_afd_spi_host.xfer(1'b1, a, 8'h00);
  endtask : rd

  task automatic drive(input int ch, input int v);
    if (ch == 0) begin
      smp_a <= v[13:0];
    end else begin
      smp_b <= v[13:0];
    end
  endtask : drive

  // scoreboard: each returned byte against the oldest note
  always @(posedge i_mclk) begin
    if (rvalid === 1'b1) begin
      e = exp_q.pop_front();
      check({8'h00, rdata}, {8'h00, e});
    end
  end

  // decimated strobe every 4 clocks, floating sdo pattern, hang guard
  always @(posedge i_mclk) begin
    sdo_fill <= ~sdo_fill;
    dec_en   <= (cyc % 4 == 0);
    cyc++;
    if (cyc == 60000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    i_rst = 1'b1;
    smp_a = 14'h0000;
    smp_b = 14'h0000;
    core_ovr = 2'h0;
    vc_ovr = 4'h0;
    dec_en = 1'b0;
    sdo_fill = 1'b0;
    hit = 1'b0;
    void'($urandom(46621));
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (8) @(posedge i_mclk);
    // reset values, random read-back, unmapped address
    foreach (RA[i]) rd(RA[i], 8'h00);
    rd(`AFD_A_PKA0, 8'h00);
    foreach (RA[i]) begin
      v8[i] = 8'($urandom);
      wr(RA[i], v8[i]);
    end
    foreach (RA[i]) rd(RA[i], v8[i]);
    wr(15'h300, 8'h5a);
    rd(15'h300, 8'h00);
    $display("test registers done");
    // sticky overrange bits and their clear
    @(posedge i_mclk);
    vc_ovr <= 4'h5;
    @(posedge i_mclk);
    vc_ovr <= 4'h0;
    rd(`AFD_A_ORS, 8'h05);
    wr(`AFD_A_ORS, 8'hff);
    rd(`AFD_A_ORS, 8'h05);
    wr(`AFD_A_ORC, 8'h01);
    wr(`AFD_A_ORC, 8'h00);
    rd(`AFD_A_ORS, 8'h04);
    $display("test sticky done");
    // status pair latency, then blocked while selected
    @(posedge i_mclk);
    core_ovr <= 2'b10;
    @(posedge i_mclk);
    core_ovr <= 2'b00;
    n = 1;
    #1;
    while (st_p !== 1'b1 && n < 8) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    check(16'(n), 16'(LAT + 1));
    check({15'h0, st_n}, 16'h0000);
    fork
      rd(`AFD_A_FDC, 8'h00);
      begin
        repeat (40) @(posedge i_mclk);
        core_ovr <= 2'b01;
        @(posedge i_mclk);
        core_ovr <= 2'b00;
        repeat (10) begin
          @(posedge i_mclk);
          hit = hit | st_p;
        end
        check({15'h0, hit}, 16'h0000);
      end
    join
    $display("test status done");
    // fast detect: disabled first, then set and hysteresis per channel
    wr16(`AFD_A_UTH0, 16'd1000);
    wr16(`AFD_A_LTH0, 16'd500);
    wr16(`AFD_A_DWL0, 16'(DWL));
    @(posedge i_mclk);
    smp_a <= 14'd2000;
    smp_b <= -14'sd2000;
    repeat (6) @(posedge i_mclk);
    #1;
    check({14'h0, fl}, 16'h0000);
    @(posedge i_mclk);
    smp_a <= 14'h0000;
    smp_b <= 14'h0000;
    wr(`AFD_A_FDC, 8'h01);
    for (int ch = 0; ch < 2; ch++) begin
      @(posedge i_mclk);
      drive(ch, ch ? -2000 : 2000);
      @(posedge i_mclk);
      drive(ch, 700);
      n = 1;
      #1;
      while (fl[ch] !== 1'b1 && n < 28) begin
        @(posedge i_mclk);
        #1;
        n++;
      end
      check({15'h0, fl[ch]}, 16'h0001);
      check({15'h0, fl[1 - ch]}, 16'h0000);
      @(posedge i_mclk);
      drive(ch, -100);
      repeat (DWL - 1) @(posedge i_mclk);
      drive(ch, 600);
      @(posedge i_mclk);
      drive(ch, 100);
      n = 0;
      #1;
      while (fl[ch] === 1'b1 && n < 20) begin
        @(posedge i_mclk);
        #1;
        n++;
      end
      check(16'(n >= DWL + 2 && n <= DWL + 3), 16'h0001);
      @(posedge i_mclk);
      drive(ch, 0);
    end
    $display("test fast detect done");
    // peak monitor: period first, then enable, then two levels
    wr(`AFD_A_PER0, 8'h04);
    wr(`AFD_A_PER1, 8'h00);
    wr(`AFD_A_PER2, 8'h00);
    wr(`AFD_A_SMC, 8'h02);
    pa = $urandom_range(8191, 1000);
    pb = $urandom_range(999, 1);
    pa2 = pa / 2;
    @(posedge i_mclk);
    smp_a <= 14'(-pa);
    smp_b <= 14'(pb);
    repeat (40) @(posedge i_mclk);
    rd(`AFD_A_PKA0, pa[7:0]);
    rd(`AFD_A_PKA1, {3'h0, pa[12:8]});
    rd(`AFD_A_PKB0, pb[7:0]);
    rd(`AFD_A_PKB1, {3'h0, pb[12:8]});
    @(posedge i_mclk);
    smp_a <= 14'(pa2);
    repeat (40) @(posedge i_mclk);
    rd(`AFD_A_PKA0, pa2[7:0]);
    rd(`AFD_A_PKA1, {3'h0, pa2[12:8]});
    $display("test peak monitor done");
    repeat (4) @(posedge i_mclk);
    finish_test();
  end
endmodule : afd_top_tb
`default_nettype wire
